// >>> src/isr_consts.svh
// Constants for the status, temperature and queue readout register bank.
// Assumes an APB slave with 32-bit data; printed offsets are word indexes.
`ifndef ISR_CONSTS_SVH
`define ISR_CONSTS_SVH
`define ISR_IDX_STATE      6'h21
`define ISR_IDX_TEMP_LO    6'h22
`define ISR_IDX_TEMP_HI    6'h23
`define ISR_IDX_FILL_LO    6'h24
`define ISR_IDX_FILL_HI    6'h25
`define ISR_IDX_PORT       6'h26
`define ISR_IDX_IRQ_STAT   6'h28
`define ISR_IDX_IRQ_MASK   6'h29
`define ISR_ST_NOT_INIT    4'h0
`define ISR_ST_INIT_OK     4'h1
`define ISR_ST_LAST        4'h7
`define ISR_TEMP_INVALID   16'h8000
`define ISR_TEMP_RST_HI    8'h80
`define ISR_TEMP_RST_LO    8'h00
`define ISR_CLK_MHZ        200
`define ISR_NORM_MS        10
`define ISR_NORM_CYC       (`ISR_NORM_MS * 1000 * `ISR_CLK_MHZ)
`define ISR_ST_TIME_BIT    15
`define ISR_FILL_W         14
`define ISR_FRAME_MAX      8'd32
`define ISR_IRQ_W          3
`define ISR_IRQ_TEMP       0
`define ISR_IRQ_FRAME      1
`define ISR_IRQ_FAULT      2
`endif

// >>> src/isr_pkg.sv
// Types for the status, temperature and queue readout register bank.
// Assumes the constants header is included by the design file.
`default_nettype none
package isr_pkg;
	// Gyroscope power state as seen by the temperature logic.
	typedef enum logic [1:0] {ISR_GYR_SUSPEND, ISR_GYR_NORMAL, ISR_GYR_STANDBY} isr_gyr_t;
endpackage : isr_pkg
`default_nettype wire

// >>> src/isr_readout.sv
// APB register bank: internal status, temperature word, queue fill level, queue read port.
// Assumes queue storage, frame assembly and the sensing datapath live outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "isr_consts.svh"
module isr_readout #(
	parameter int unsigned NORM_CYC = `ISR_NORM_CYC // Normal refresh period in cycles.
) (
	input  wire logic        i_ref_clk,      // Device clock, 200 MHz.
	input  wire logic        i_rst,          // Asynchronous reset, active high.
	input  wire logic        i_psel,         // APB select.
	input  wire logic        i_penable,      // APB access phase.
	input  wire logic        i_pwrite,       // APB direction.
	input  wire logic [11:0] i_paddr,        // APB byte address.
	input  wire logic [31:0] i_pwdata,       // APB write data.
	output logic      [31:0] o_prdata,       // APB read data.
	output logic             o_pready,       // APB ready.
	output logic             o_pslverr,      // APB error.
	input  wire logic [3:0]  i_state_code,   // Internal status message.
	input  wire logic        i_remap_fault,  // Axes remapping fault.
	input  wire logic        i_min_rate_fault_flag, // Bandwidth fault.
	input  wire isr_pkg::isr_gyr_t i_gyr_mode, // Gyroscope power state.
	input  wire logic        i_all_suspend,  // Every sensor suspended.
	input  wire logic [15:0] i_sensor_time,  // Low bits of sensor time.
	input  wire logic [15:0] i_temp_sample,  // Live converter result.
	input  wire logic        i_frame_wr,     // Whole frame written, one-cycle pulse.
	input  wire logic [7:0]  i_frame_len,    // Bytes in the written frame.
	input  wire logic        i_queue_flush,  // Queue reset command pulse.
	input  wire logic [7:0]  i_queue_byte,   // Byte at the current read pointer.
	input  wire logic [7:0]  i_head_len,     // Bytes in the frame at the head.
	output logic             o_byte_pop,     // Advance read pointer, pulse.
	output logic             o_frame_done,   // Head frame fully read, pulse.
	output logic             o_frame_rewind, // Rewind to head frame start, pulse.
	output logic             o_irq           // Level interrupt.
);
	// Decoded access: taken once, on the first access-phase edge, while ready is still low.
	// Gating with ready keeps the second access edge, at which the master samples ready,
	// from popping, latching or writing a second time.
	logic       acc;    // Access taken at this edge.
	logic       rd;     // Read taken at this edge.
	logic       wr;     // Write taken at this edge.
	logic [5:0] idx;    // Register index, the byte address over four.
	logic       mapped; // Address decodes to a register of this bank.
	assign acc = i_psel && i_penable && !o_pready;
	assign rd = acc && !i_pwrite;
	assign wr = acc && i_pwrite;
	assign idx = i_paddr[7:2];
	assign mapped = (i_paddr[11:8] == 4'h0) && (i_paddr[1:0] == 2'h0) &&
		(((idx >= `ISR_IDX_STATE) && (idx <= `ISR_IDX_PORT)) ||
		(idx == `ISR_IDX_IRQ_STAT) || (idx == `ISR_IDX_IRQ_MASK));

	// Temperature word, refresh timer, coherency latches and fill level.
	// Every pair below is registered once in the single clocked process further down.
	logic [15:0] temp_reg, temp_next;
	logic [31:0] tick_reg, tick_next;
	logic        st_bit_reg, st_bit_next;
	logic [7:0]  temp_hi_lat_reg, temp_hi_lat_next;
	logic [5:0]  fill_hi_lat_reg, fill_hi_lat_next;
	logic [`ISR_FILL_W-1:0] fill_reg, fill_next;
	logic [7:0]  part_reg, part_next;
	logic        in_burst_reg, in_burst_next;
	logic [`ISR_IRQ_W-1:0] stat_reg, stat_next;
	logic [`ISR_IRQ_W-1:0] mask_reg, mask_next;
	logic [31:0] prdata_next;
	logic        pslverr_next;
	logic        pop_next, done_next, rewind_next, irq_next;
	logic        temp_upd;
	logic        fault_now;
	logic        fault_prev_reg;
	logic [`ISR_IRQ_W-1:0] ev;

	// Next-state logic for the whole bank.
	always_comb
	begin
		temp_next = temp_reg;
		tick_next = tick_reg;
		st_bit_next = i_sensor_time[`ISR_ST_TIME_BIT];
		temp_hi_lat_next = temp_hi_lat_reg;
		fill_hi_lat_next = fill_hi_lat_reg;
		fill_next = fill_reg;
		part_next = part_reg;
		in_burst_next = in_burst_reg;
		stat_next = stat_reg;
		mask_next = mask_reg;
		prdata_next = 32'h0;
		pslverr_next = 1'b0;
		pop_next = 1'b0;
		done_next = 1'b0;
		rewind_next = 1'b0;
		temp_upd = 1'b0;
		// Every message above init_ok is an error code, so it counts as a fault.
		fault_now = i_remap_fault || i_min_rate_fault_flag || (i_state_code > `ISR_ST_INIT_OK);
		// Refresh scheduling; the timer is parked while no refresh may happen.
		if (i_all_suspend || (i_gyr_mode == isr_pkg::ISR_GYR_SUSPEND))
		begin
			tick_next = 32'h0;
		end
		else if (i_gyr_mode == isr_pkg::ISR_GYR_NORMAL)
		begin
			if (tick_reg >= NORM_CYC - 1)
			begin
				tick_next = 32'h0;
				temp_upd = 1'b1;
			end
			else
			begin
				tick_next = tick_reg + 32'h1;
			end
		end
		else
		begin
			// Standby: refresh on each edge of sensor time bit 15.
			tick_next = 32'h0;
			temp_upd = (st_bit_reg != i_sensor_time[`ISR_ST_TIME_BIT]);
		end
		if (temp_upd && !i_all_suspend)
		begin
			// A sample equal to the invalid code is never produced by a real reading.
			temp_next = (i_gyr_mode == isr_pkg::ISR_GYR_NORMAL) ? i_temp_sample :
				`ISR_TEMP_INVALID;
		end
		// Fill level moves by whole frames only; partial reads leave it.
		if (i_frame_wr)
		begin
			fill_next = fill_reg + {6'h0, i_frame_len};
		end
		// Register reads; read-only registers ignore writes and answer without error.
		// Low-byte reads latch the high half so that a following high read is coherent.
		if (rd && mapped)
		begin
			case (idx)
				`ISR_IDX_STATE:   prdata_next = {24'h0, 1'b0, i_min_rate_fault_flag,
					i_remap_fault, 1'b0, i_state_code};
				`ISR_IDX_TEMP_LO:
				begin
					prdata_next = {24'h0, temp_reg[7:0]};
					temp_hi_lat_next = temp_reg[15:8];
				end
				`ISR_IDX_TEMP_HI: prdata_next = {24'h0, temp_hi_lat_reg};
				`ISR_IDX_FILL_LO:
				begin
					prdata_next = {24'h0, fill_reg[7:0]};
					fill_hi_lat_next = fill_reg[13:8];
				end
				`ISR_IDX_FILL_HI: prdata_next = {26'h0, fill_hi_lat_reg};
				`ISR_IDX_PORT:
				begin
					// Each read of a non-empty queue takes one byte; new-data flags are outside and untouched.
					prdata_next = (fill_reg == '0) ? 32'h0 : {24'h0, i_queue_byte};
					if (fill_reg != '0)
					begin
						pop_next = 1'b1;
						in_burst_next = 1'b1;
						if (part_reg + 8'h1 >= i_head_len)
						begin
							part_next = 8'h0;
							done_next = 1'b1;
							fill_next = fill_next - {6'h0, i_head_len};
						end
						else
						begin
							part_next = part_reg + 8'h1;
						end
					end
				end
				`ISR_IDX_IRQ_STAT: prdata_next = {29'h0, stat_reg};
				`ISR_IDX_IRQ_MASK: prdata_next = {29'h0, mask_reg};
				default:          prdata_next = 32'h0;
			endcase
		end
		else if (acc && !mapped)
		begin
			pslverr_next = 1'b1;
		end
		// Burst ends when an access leaves the port; a partial frame is rewound.
		if (acc && (!rd || (idx != `ISR_IDX_PORT)) && in_burst_reg)
		begin
			in_burst_next = 1'b0;
			if (part_reg != 8'h0)
			begin
				part_next = 8'h0;
				rewind_next = 1'b1;
			end
		end
		// A flush overrides whatever frames moved in the same cycle, so the count
		// can never wrap below zero when a drain and a flush coincide.
		if (i_queue_flush)
		begin
			fill_next = '0;
			part_next = 8'h0;
			in_burst_next = 1'b0;
		end
		// Sticky events; set wins over a write-one clear in the same cycle.
		// Faults are taken as rising edges, so a fault level raises its bit only once.
		ev = '0;
		ev[`ISR_IRQ_TEMP] = temp_upd && !i_all_suspend;
		ev[`ISR_IRQ_FRAME] = i_frame_wr;
		ev[`ISR_IRQ_FAULT] = fault_now && !fault_prev_reg;
		if (wr && (idx == `ISR_IDX_IRQ_STAT) && mapped)
		begin
			stat_next = stat_reg & ~i_pwdata[`ISR_IRQ_W-1:0];
		end
		if (wr && (idx == `ISR_IDX_IRQ_MASK) && mapped)
		begin
			mask_next = i_pwdata[`ISR_IRQ_W-1:0];
		end
		stat_next = stat_next | ev;
		irq_next = |(stat_next & mask_next);
	end

	// Registering of all state; reset puts the invalid code in the word.
	// Outputs stay low through reset, so the master never sees a stray ready.
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			temp_reg <= {`ISR_TEMP_RST_HI, `ISR_TEMP_RST_LO};
			tick_reg <= 32'h0;
			st_bit_reg <= 1'b0;
			temp_hi_lat_reg <= `ISR_TEMP_RST_HI;
			fill_hi_lat_reg <= 6'h0;
			fill_reg <= '0;
			part_reg <= 8'h0;
			in_burst_reg <= 1'b0;
			stat_reg <= '0;
			mask_reg <= '0;
			fault_prev_reg <= 1'b0;
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_byte_pop <= 1'b0;
			o_frame_done <= 1'b0;
			o_frame_rewind <= 1'b0;
			o_irq <= 1'b0;
		end
		else
		begin
			temp_reg <= temp_next;
			tick_reg <= tick_next;
			st_bit_reg <= st_bit_next;
			temp_hi_lat_reg <= temp_hi_lat_next;
			fill_hi_lat_reg <= fill_hi_lat_next;
			fill_reg <= fill_next;
			part_reg <= part_next;
			in_burst_reg <= in_burst_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			fault_prev_reg <= fault_now;
			o_prdata <= prdata_next;
			// Ready comes one cycle into the access phase, so each transfer waits once.
			o_pready <= acc && !o_pready;
			o_pslverr <= pslverr_next && acc && !o_pready;
			o_byte_pop <= pop_next && !o_pready;
			o_frame_done <= done_next && !o_pready;
			o_frame_rewind <= rewind_next && !o_pready;
			o_irq <= irq_next;
		end
	end

	// Checks on the bank's behaviour.
	property p_flush_zero;
		@(posedge i_ref_clk) disable iff (i_rst) i_queue_flush |=> (fill_reg == '0);
	endproperty
	a_flush_zero: assert property (p_flush_zero) else $error("Fill not zero after flush.");
	property p_suspend_hold;
		@(posedge i_ref_clk) disable iff (i_rst) i_all_suspend |=> $stable(temp_reg);
	endproperty
	a_suspend_hold: assert property (p_suspend_hold) else $error("Temperature moved in suspend.");
	property p_standby_invalid;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_gyr_mode == isr_pkg::ISR_GYR_STANDBY) && !i_all_suspend &&
		$changed(i_sensor_time[`ISR_ST_TIME_BIT]) |=> ##1 (temp_reg == `ISR_TEMP_INVALID);
	endproperty
	a_standby_invalid: assert property (p_standby_invalid) else $error("Standby word not invalid.");
	property p_pready_pulse;
		@(posedge i_ref_clk) disable iff (i_rst) o_pready |=> !o_pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("Ready held two cycles.");
	property p_no_partial_move;
		@(posedge i_ref_clk) disable iff (i_rst)
		!i_queue_flush && !i_frame_wr && !done_next |=> $stable(fill_reg);
	endproperty
	a_no_partial_move: assert property (p_no_partial_move) else $error("Fill moved mid frame.");
	property p_irq_level;
		@(posedge i_ref_clk) disable iff (i_rst) ##1 (o_irq == |(stat_reg & mask_reg));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt level mismatch.");
	property p_empty_no_pop;
		@(posedge i_ref_clk) disable iff (i_rst) (fill_reg == '0) && !i_frame_wr |=> !o_byte_pop;
	endproperty
	a_empty_no_pop: assert property (p_empty_no_pop) else $error("Pop from empty queue.");
	property p_rewind_partial;
		@(posedge i_ref_clk) disable iff (i_rst) o_frame_rewind |-> (part_reg == 8'h0);
	endproperty
	a_rewind_partial: assert property (p_rewind_partial) else $error("Rewind left position.");
	// Every taken access is answered with ready on the next cycle.
	property p_rdy_follows;
		@(posedge i_ref_clk) disable iff (i_rst) acc |=> o_pready;
	endproperty
	a_rdy_follows: assert property (p_rdy_follows) else $error("No ready after access.");
	// An error answer only ever rides on a ready pulse.
	property p_err_rdy;
		@(posedge i_ref_clk) disable iff (i_rst) o_pslverr |-> o_pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("Error without ready.");
	// A byte leaves the queue only as the answer to a port read.
	property p_pop_rdy;
		@(posedge i_ref_clk) disable iff (i_rst) o_byte_pop |-> o_pready;
	endproperty
	a_pop_rdy: assert property (p_pop_rdy) else $error("Pop without ready.");
	// A frame completes only on the read that takes its last byte.
	property p_done_pop;
		@(posedge i_ref_clk) disable iff (i_rst) o_frame_done |-> o_byte_pop;
	endproperty
	a_done_pop: assert property (p_done_pop) else $error("Done without pop.");
	// A normal-mode refresh copies the converter word seen at the tick.
	property p_norm_copy;
		@(posedge i_ref_clk) disable iff (i_rst)
		(i_gyr_mode == isr_pkg::ISR_GYR_NORMAL) && !i_all_suspend &&
		(tick_reg >= NORM_CYC - 1) |=> (temp_reg == $past(i_temp_sample));
	endproperty
	a_norm_copy: assert property (p_norm_copy) else $error("Refresh lost sample.");
	// A refresh decided in standby never publishes a live reading.
	property p_idle_invalid;
		@(posedge i_ref_clk) disable iff (i_rst)
		($past(i_gyr_mode) == isr_pkg::ISR_GYR_STANDBY) && $changed(temp_reg) |->
		(temp_reg == `ISR_TEMP_INVALID);
	endproperty
	a_idle_invalid: assert property (p_idle_invalid) else $error("Live word in standby.");
	// A low temperature read freezes the high half that goes with it.
	property p_tlo_latch;
		@(posedge i_ref_clk) disable iff (i_rst)
		rd && mapped && (idx == `ISR_IDX_TEMP_LO) |=> (temp_hi_lat_reg == $past(temp_reg[15:8]));
	endproperty
	a_tlo_latch: assert property (p_tlo_latch) else $error("High half not latched.");
	// With every source masked the interrupt line stays low.
	property p_irq_quiet;
		@(posedge i_ref_clk) disable iff (i_rst) (mask_reg == '0) && !wr |=> !o_irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("Masked interrupt raised.");
	// Every event lands in the status register, whatever software clears.
	property p_stat_set;
		@(posedge i_ref_clk) disable iff (i_rst)
		(ev != '0) |=> ((stat_reg & $past(ev)) == $past(ev));
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("Event bit not set.");
	// A port read of an empty queue answers zero.
	property p_empty_zero;
		@(posedge i_ref_clk) disable iff (i_rst)
		rd && mapped && (idx == `ISR_IDX_PORT) && (fill_reg == '0) |=> (o_prdata == 32'h0);
	endproperty
	a_empty_zero: assert property (p_empty_zero) else $error("Empty port not zero.");
	c_normal_upd: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_gyr_mode == isr_pkg::ISR_GYR_NORMAL) && temp_upd);
	c_frame_done: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_frame_done);
	c_rewind: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_frame_rewind);
	c_irq: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_irq));
	c_port_err: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_pslverr);
endmodule : isr_readout
`default_nettype wire

// >>> test/isr_host_model.sv
// Host controller stand-in: an APB master driven through its transfer task.
// Assumes the register bank shares its clock and answers with pready.
`timescale 1ns/10ps
`default_nettype none
module isr_host_model (
	input  wire logic        i_ref_clk, // Shared device clock.
	input  wire logic        i_pready,  // Slave ready.
	input  wire logic        i_pslverr, // Slave error.
	input  wire logic [31:0] i_prdata,  // Slave read data.
	output logic             o_psel,    // Select.
	output logic             o_penable, // Access phase.
	output logic             o_pwrite,  // Direction.
	output logic      [11:0] o_paddr,   // Byte address.
	output logic      [31:0] o_pwdata   // Write data.
);
	// Idle bus from time zero so the bank never sees an unknown select.
	initial
	begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 12'h000;
		o_pwdata  = 32'h0;
	end
	// One whole transfer with an idle cycle before it; waits as long as the slave needs.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge i_ref_clk);
		o_psel   <= 1'b1;
		o_pwrite <= w;
		o_paddr  <= a;
		o_pwdata <= d;
		@(posedge i_ref_clk);
		o_penable <= 1'b1;
		do @(posedge i_ref_clk); while (i_pready !== 1'b1);
		q = i_prdata;
		e = i_pslverr;
		// Released lines show the inverse, so a stale value is never mistaken for a live one.
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
		o_paddr   <= ~a;
		o_pwdata  <= ~d;
	endtask : xfer
endmodule : isr_host_model
`default_nettype wire

// >>> test/imu_status_temp_fifo_readout_tb_top.sv
// Self-checking bench for the status, temperature and queue readout bank.
// Assumes the host model file is compiled first; the queue storage is emulated here.
`timescale 1ns/10ps
`default_nettype none
module imu_status_temp_fifo_readout_tb_top;
	localparam int unsigned NCYC = 20; // Shortened normal refresh period.
	logic              clk, rst, psel, pen, pwr, pready, slverr, remap, rate, allsus;
	logic              fwr, flush, pop, done, rew, irq, err;
	logic       [11:0] paddr;
	logic       [31:0] pwdata, prdata, q;
	logic        [3:0] code;
	logic       [15:0] stime, tsamp;
	logic        [7:0] flen, hlen, qbyte, rptr, hbase;
	isr_pkg::isr_gyr_t gmode;
	int                err_total, samples_checked, i;
	isr_host_model host_u (.i_ref_clk(clk), .i_pready(pready), .i_pslverr(slverr),
		.i_prdata(prdata), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
		.o_paddr(paddr), .o_pwdata(pwdata));
	isr_readout #(.NORM_CYC(NCYC)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr), .i_state_code(code),
		.i_remap_fault(remap), .i_min_rate_fault_flag(rate), .i_gyr_mode(gmode),
		.i_all_suspend(allsus), .i_sensor_time(stime), .i_temp_sample(tsamp),
		.i_frame_wr(fwr), .i_frame_len(flen), .i_queue_flush(flush), .i_queue_byte(qbyte),
		.i_head_len(hlen), .o_byte_pop(pop), .o_frame_done(done), .o_frame_rewind(rew),
		.o_irq(irq));
	// Clock at 200 MHz.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Queue storage stand-in: each byte is 0xa0 plus its position, so order errors show.
	assign qbyte = 8'ha0 + rptr;
	always @(posedge clk)
	begin
		if (rew)
			rptr <= hbase;
		else if (pop)
			rptr <= rptr + 8'h01;
		if (done)
			hbase <= hbase + hlen;
	end
	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Reads one register and compares it.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		host_u.xfer(1'b0, a, 32'h0, q, err);
		check(q, exp);
	endtask : rd
	// Announces one whole written frame.
	task automatic frame(input logic [7:0] len);
		@(posedge clk);
		fwr  <= 1'b1;
		flen <= len;
		@(posedge clk);
		fwr <= 1'b0;
	endtask : frame
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// Watchdog: the sequence needs far fewer than 20000 cycles.
	initial
	begin
		#100us;
		err_total++;
		close_out();
	end
	initial
	begin
		{rst, remap, rate, allsus, fwr, flush} = 6'h20;
		{code, stime, tsamp, flen, hlen, rptr, hbase} = {4'h0, 16'h0, 16'h1234, 8'h00, 8'h05, 16'h0};
		gmode = isr_pkg::ISR_GYR_SUSPEND;
		err_total = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(12'h088, 32'h00);
		rd(12'h08c, 32'h80);
		rd(12'h090, 32'h00);
		rd(12'h094, 32'h00);
		for (i = 0; i < 8; i++)
		begin
			code  <= i[3:0];
			remap <= i[0];
			rate  <= i[1];
			rd(12'h084, {25'h0, i[1], i[0], 1'b0, i[3:0]});
		end
		// Normal mode: the word follows the converter; the high half is latched on low read.
		gmode <= isr_pkg::ISR_GYR_NORMAL;
		repeat (3 * NCYC) @(posedge clk);
		rd(12'h088, 32'h34);
		tsamp <= 16'h5678;
		repeat (3 * NCYC) @(posedge clk);
		rd(12'h08c, 32'h12);
		host_u.xfer(1'b1, 12'h088, 32'hff, q, err);
		rd(12'h088, 32'h78);
		// All suspended, then standby: no refresh until sensor time bit 15 moves.
		{allsus, tsamp} <= {1'b1, 16'h0bad};
		gmode <= isr_pkg::ISR_GYR_SUSPEND;
		repeat (3 * NCYC) @(posedge clk);
		rd(12'h088, 32'h78);
		allsus <= 1'b0;
		gmode  <= isr_pkg::ISR_GYR_STANDBY;
		repeat (3 * NCYC) @(posedge clk);
		rd(12'h088, 32'h78);
		stime <= 16'h8000;
		repeat (4) @(posedge clk);
		rd(12'h088, 32'h00);
		rd(12'h08c, 32'h80);
		// Two frames, a frame interrupt raised and cleared, partial read then full drain.
		host_u.xfer(1'b1, 12'h0a4, 32'h2, q, err);
		frame(8'h05);
		frame(8'h05);
		rd(12'h090, 32'h0a);
		check({31'h0, irq}, 32'h1);
		rd(12'h0a0, 32'h7);
		rd(12'h0a4, 32'h2);
		host_u.xfer(1'b1, 12'h0a0, 32'h7, q, err);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd(12'h0a0, 32'h0);
		for (i = 0; i < 3; i++)
			rd(12'h098, 32'ha0 + i);
		rd(12'h090, 32'h0a);
		for (i = 0; i < 10; i++)
			rd(12'h098, 32'ha0 + i);
		rd(12'h090, 32'h00);
		rd(12'h098, 32'h00);
		// Large fill reaching the upper bits, then a flush.
		for (i = 0; i < 9; i++)
			frame(8'h20);
		rd(12'h090, 32'h20);
		rd(12'h094, 32'h01);
		@(posedge clk);
		flush <= 1'b1;
		@(posedge clk);
		flush <= 1'b0;
		rd(12'h090, 32'h00);
		host_u.xfer(1'b0, 12'h100, 32'h0, q, err);
		check({31'h0, err}, 32'h1);
		close_out();
	end
endmodule : imu_status_temp_fifo_readout_tb_top
`default_nettype wire
